// file: rtl/mai_top.sv
// Motion-adaptive interpolation selector with AHB-Lite register slave and output buffer
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mai_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Override selects
   input wire logic override_sel_1,
   input wire logic override_sel_2,
   // Field store samples
   input wire logic pix_valid,
   output logic pix_ready,
   input wire logic [mai_pkg::NUM_CHAN*mai_pkg::SAMPLE_W-1:0] cur_sample,
   input wire logic [mai_pkg::NUM_CHAN*mai_pkg::SAMPLE_W-1:0] adj_field_sample,
   input wire logic [mai_pkg::NUM_CHAN*mai_pkg::SAMPLE_W-1:0] next_frame_sample,
   // Interpolator selects
   output logic sel_valid,
   input wire logic sel_ready,
   output logic [mai_pkg::NUM_CHAN-1:0] sel_frame
);
   localparam int NC = mai_pkg::NUM_CHAN;
   localparam int SW = mai_pkg::SAMPLE_W;
   localparam int TW = mai_pkg::THR_W;
   localparam int LW = mai_pkg::LANES * mai_pkg::THR_W;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Threshold register address decode
   function automatic logic mai_thr_hit(input logic [11:0] a);
      mai_thr_hit = (a[11:6] == 6'h00) && (a[5:4] != 2'h0) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
   endfunction : mai_thr_hit

   // Motion acceptable for two-field use at threshold percentage
   function automatic logic mai_ok(input logic [SW-1:0] m, input logic [TW-1:0] t);
      logic [15:0] lhs;
      logic [15:0] rhs;
      lhs = 16'(m) * mai_pkg::PCT_FULL;
      rhs = 16'(t) * mai_pkg::SAMPLE_FULL;
      mai_ok = (16'(t) >= mai_pkg::PCT_FULL) || (lhs < rhs);
   endfunction : mai_ok

   function automatic logic [TW-1:0] mai_clamp(input logic [7:0] v);
      mai_clamp = (16'(v) > mai_pkg::PCT_FULL) ? mai_pkg::PCT_FULL[TW-1:0] : v;
   endfunction : mai_clamp

   // Registers and bus state
   mai_pkg::mai_mode_t mode;
   mai_pkg::mai_target_t target;
   logic pend;
   logic a_wr;
   logic [11:0] a_addr;
   logic [1:0] act_set;
   logic ov1_s1, ov1_s2, ov2_s1, ov2_s2;
   logic [15:0] fld_count;
   logic [1:0] count;
   logic [NC-1:0] tail;
   logic [LW-1:0] thr_now;
   logic [LW-1:0] thr_bus;
   logic accept;
   logic push;
   logic pop;
   logic thr_wr;
   logic [mai_pkg::LANES-1:0] wr_lane;
   logic [LW-1:0] wr_data;
   logic [1:0] next_count;
   logic [NC-1:0] sel_new;
   logic [NC-1:0] ok_fld;
   logic [NC-1:0] ok_frm;
   logic [SW-1:0] mot_fld [NC];
   logic [SW-1:0] mot_frm [NC];

   assign accept = hsel && htrans[1] && hready;
   assign thr_wr = pend && a_wr && mai_thr_hit(a_addr);

   // AHB-Lite transfer sequencing, one wait state per transfer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
         a_wr <= 1'b0;
         a_addr <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (pend) begin
         pend <= 1'b0;
         hreadyout <= 1'b1;
      end else if (accept) begin
         pend <= 1'b1;
         a_wr <= hwrite;
         a_addr <= haddr[11:0];
         hreadyout <= 1'b0;
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= mai_pkg::mai_mode_t'(mai_pkg::CTRL_MODE_RST);
         target <= mai_pkg::mai_target_t'(mai_pkg::CTRL_TARGET_RST);
      end else if (pend && a_wr && (a_addr == mai_pkg::ADDR_CTRL)) begin
         mode <= (hwdata[mai_pkg::CTRL_MODE_LSB +: 2] == 2'h3) ? mai_pkg::MAI_MOTION_ADAPTIVE_SETTING :
                 mai_pkg::mai_mode_t'(hwdata[mai_pkg::CTRL_MODE_LSB +: 2]);
         target <= (hwdata[mai_pkg::CTRL_TARGET_LSB +: 2] == 2'h3) ? mai_pkg::MAI_EDIT_BOTH :
                   mai_pkg::mai_target_t'(hwdata[mai_pkg::CTRL_TARGET_LSB +: 2]);
      end
   end

   always_comb begin
      wr_lane = '0;
      wr_data = '0;
      for (int c = 0; c < NC; c++) begin
         wr_data[(2*c)*TW +: TW] = mai_clamp(hwdata[mai_pkg::THR_FIELD_LSB +: 8]);
         wr_data[(2*c+1)*TW +: TW] = (target == mai_pkg::MAI_EDIT_BOTH) ?
                                     mai_clamp(hwdata[mai_pkg::THR_FIELD_LSB +: 8]) :
                                     mai_clamp(hwdata[mai_pkg::THR_FRAME_LSB +: 8]);
         if (int'(a_addr[3:2]) == c) begin
            wr_lane[2*c] = (target != mai_pkg::MAI_EDIT_FRAME);
            wr_lane[2*c+1] = (target != mai_pkg::MAI_EDIT_FIELD);
         end
      end
   end

   mai_thr_mem #(
      .DEPTH(mai_pkg::NUM_SETS),
      .LANES(mai_pkg::LANES),
      .LANE_W(TW),
      .RST_VAL(mai_pkg::THR_RST)
   ) u_thr_mem (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(thr_wr),
      .wr_addr(a_addr[5:4] - 2'h1),
      .wr_lane(wr_lane),
      .wr_data(wr_data),
      .rd_a_addr(act_set),
      .rd_a_data(thr_now),
      .rd_b_addr(haddr[5:4] - 2'h1),
      .rd_b_data(thr_bus)
   );

   // Read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (pend && !a_wr) begin
         hrdata <= 32'h00000000;
         if (a_addr == mai_pkg::ADDR_CTRL) begin
            hrdata[mai_pkg::CTRL_MODE_LSB +: 2] <= mode;
            hrdata[mai_pkg::CTRL_TARGET_LSB +: 2] <= target;
         end else if (a_addr == mai_pkg::ADDR_STATUS) begin
            hrdata[mai_pkg::STAT_SET_LSB +: 2] <= act_set;
            hrdata[mai_pkg::STAT_CNT_LSB +: 2] <= count;
            hrdata[mai_pkg::STAT_FLDCNT_LSB +: 16] <= fld_count;
         end else if (mai_thr_hit(a_addr)) begin
            hrdata[mai_pkg::THR_FIELD_LSB +: TW] <= thr_bus[(2*a_addr[3:2])*TW +: TW];
            hrdata[mai_pkg::THR_FRAME_LSB +: TW] <= thr_bus[(2*a_addr[3:2]+1)*TW +: TW];
         end
      end
   end

   // Override select synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ov1_s1 <= 1'b0;
         ov1_s2 <= 1'b0;
         ov2_s1 <= 1'b0;
         ov2_s2 <= 1'b0;
      end else begin
         ov1_s1 <= override_sel_1;
         ov1_s2 <= ov1_s1;
         ov2_s1 <= override_sel_2;
         ov2_s2 <= ov2_s1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_set <= 2'h0;
      end else begin
         act_set <= ov1_s2 ? 2'h1 : (ov2_s2 ? 2'h2 : 2'h0);
      end
   end

   for (genvar c = 0; c < NC; c++) begin : g_chan
      logic [SW-1:0] cur;
      logic [SW-1:0] adj;
      logic [SW-1:0] nxt;
      assign cur = cur_sample[c*SW +: SW];
      assign adj = adj_field_sample[c*SW +: SW];
      assign nxt = next_frame_sample[c*SW +: SW];
      assign mot_fld[c] = (cur > adj) ? cur - adj : adj - cur;
      assign mot_frm[c] = (cur > nxt) ? cur - nxt : nxt - cur;
      assign ok_fld[c] = mai_ok(mot_fld[c], thr_now[(2*c)*TW +: TW]);
      assign ok_frm[c] = mai_ok(mot_frm[c], thr_now[(2*c+1)*TW +: TW]);
      assign sel_new[c] = (mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING) ? (ok_fld[c] && ok_frm[c]) :
                          (mode == mai_pkg::MAI_FRAME);
   end

   // Two-entry output buffer
   assign push = pix_valid && pix_ready;
   assign pop = sel_valid && sel_ready;
   assign next_count = count + 2'(push) - 2'(pop);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 2'h0;
         pix_ready <= 1'b1;
         sel_valid <= 1'b0;
      end else begin
         count <= next_count;
         pix_ready <= (next_count != 2'(mai_pkg::BUF_DEPTH));
         sel_valid <= (next_count != 2'h0);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_frame <= '0;
         tail <= '0;
      end else begin
         if (pop && (count == 2'h2)) begin
            sel_frame <= tail;
         end
         if (push && ((count == 2'h0) || ((count == 2'h1) && pop))) begin
            sel_frame <= sel_new;
         end else if (push) begin
            tail <= sel_new;
         end
      end
   end

   // Pixels with any channel on single-field interpolation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fld_count <= 16'h0000;
      end else if (push && (sel_new != {NC{1'b1}})) begin
         fld_count <= fld_count + 16'h0001;
      end
   end

   logic empty_push;
   logic [15:0] fm0;
   logic [15:0] ft0;
   logic [15:0] rm0;
   logic [15:0] rt0;
   assign empty_push = push && (count == 2'h0);
   assign fm0 = 16'(mot_fld[mai_pkg::CH_LUMA]) * mai_pkg::PCT_FULL;
   assign ft0 = 16'(thr_now[0 +: TW]) * mai_pkg::SAMPLE_FULL;
   assign rm0 = 16'(mot_frm[mai_pkg::CH_LUMA]) * mai_pkg::PCT_FULL;
   assign rt0 = 16'(thr_now[TW +: TW]) * mai_pkg::SAMPLE_FULL;

   sequence s_ov1_held;
      override_sel_1 [*4];
   endsequence

   forced_field_a: assert property (empty_push && mode == mai_pkg::MAI_FIELD |=> sel_valid && sel_frame == '0)
      else $error("forced field mode did not select single field");
   forced_frame_a: assert property (empty_push && mode == mai_pkg::MAI_FRAME |=> sel_frame == '1)
      else $error("forced frame mode did not select both fields");
   field_motion_a: assert property (empty_push && mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING && fm0 > ft0 && thr_now[0 +: TW] < 8'h64
      |=> !sel_frame[0])
      else $error("field motion above threshold kept two-field use");
   frame_motion_a: assert property (empty_push && mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING && rm0 > rt0 && thr_now[TW +: TW] < 8'h64
      |=> !sel_frame[0])
      else $error("frame motion above threshold kept two-field use");
   both_below_a: assert property (empty_push && mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING && fm0 < ft0 && rm0 < rt0
      |=> sel_frame[0])
      else $error("motion below both thresholds did not select two fields");
   equal_thresh_a: assert property (empty_push && mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING && fm0 == ft0 && thr_now[0 +: TW] < 8'h64
      |=> !sel_frame[0])
      else $error("motion equal to threshold selected two fields");
   full_scale_a: assert property (empty_push && mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING && thr_now[0 +: TW] == 8'h64
      && thr_now[TW +: TW] == 8'h64 |=> sel_frame[0])
      else $error("full-scale threshold rejected motion");
   zero_thresh_a: assert property (empty_push && mode == mai_pkg::MAI_MOTION_ADAPTIVE_SETTING && thr_now[0 +: TW] == 8'h00
      |=> !sel_frame[0])
      else $error("zero threshold accepted motion");
   lane_split_a: assert property (thr_wr && target == mai_pkg::MAI_EDIT_FIELD |-> (wr_lane & 6'h2A) == 6'h00
      && $onehot(wr_lane))
      else $error("field-only edit touched a frame threshold");
   override_set_a: assert property (s_ov1_held |-> act_set == 2'h1)
      else $error("first override did not select alternate set one");
   // Buffer back-pressure
   buffer_full_a: assert property (count == 2'h2 |-> !pix_ready && !push)
      else $error("buffer accepted input while full");
endmodule : mai_top

// file: rtl/mai_pkg.sv
// Constants and types shared by the motion-adaptive interpolation selector
package mai_pkg;
   // Stream geometry
   localparam int NUM_CHAN = 3;
   localparam int SAMPLE_W = 8;
   localparam int NUM_SETS = 3;
   localparam int LANES = 2 * NUM_CHAN;
   localparam int THR_W = 8;
   localparam int BUF_DEPTH = 2;
   // Channel order inside sample vectors
   localparam int CH_LUMA = 0;
   localparam int CH_CHROMA = 1;
   localparam int CH_KEY = 2;
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_THR_BASE = 12'h010;
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TARGET_LSB = 2;
   // Status field positions
   localparam int STAT_SET_LSB = 0;
   localparam int STAT_CNT_LSB = 2;
   localparam int STAT_FLDCNT_LSB = 16;
   // Threshold word field positions
   localparam int THR_FIELD_LSB = 0;
   localparam int THR_FRAME_LSB = 8;
   // Reset values
   localparam logic [1:0] CTRL_MODE_RST = 2'h0;
   localparam logic [1:0] CTRL_TARGET_RST = 2'h0;
   localparam logic [THR_W-1:0] THR_RST = 8'h0A;
   // Percentage and sample full scale
   localparam logic [15:0] PCT_FULL = 16'h0064;
   localparam logic [15:0] SAMPLE_FULL = 16'h00FF;
   // Interpolation method and threshold edit target
   typedef enum logic [1:0] {MAI_MOTION_ADAPTIVE_SETTING, MAI_FIELD, MAI_FRAME} mai_mode_t;
   typedef enum logic [1:0] {MAI_EDIT_BOTH, MAI_EDIT_FIELD, MAI_EDIT_FRAME} mai_target_t;
endpackage : mai_pkg

// file: rtl/mai_thr_mem.sv
// Threshold store: one word per parameter set, lane write enables, two registered read ports
`timescale 1ns/1ps
module mai_thr_mem #(
   parameter int DEPTH = 3,
   parameter int LANES = 6,
   parameter int LANE_W = 8,
   parameter logic [7:0] RST_VAL = 8'h0A
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write port
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [LANES-1:0] wr_lane,
   input wire logic [LANES*LANE_W-1:0] wr_data,
   // Read port a
   input wire logic [1:0] rd_a_addr,
   output logic [LANES*LANE_W-1:0] rd_a_data,
   // Read port b
   input wire logic [1:0] rd_b_addr,
   output logic [LANES*LANE_W-1:0] rd_b_data
);
   logic [LANES*LANE_W-1:0] mem [DEPTH];

   // Storage with per-lane writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int d = 0; d < DEPTH; d++) begin
            mem[d] <= {LANES{RST_VAL[LANE_W-1:0]}};
         end
      end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
         for (int l = 0; l < LANES; l++) begin
            if (wr_lane[l]) begin
               mem[wr_addr][l*LANE_W +: LANE_W] <= wr_data[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Registered reads
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_a_data <= '0;
         rd_b_data <= '0;
      end else begin
         rd_a_data <= (int'(rd_a_addr) < DEPTH) ? mem[rd_a_addr] : '0;
         rd_b_data <= (int'(rd_b_addr) < DEPTH) ? mem[rd_b_addr] : '0;
      end
   end
endmodule : mai_thr_mem

// file: sim/mai_sink_model.sv
// Interpolator-side sink model that takes select triples with optional stalls
`timescale 1ns/1ps
module mai_sink_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Test control
   input wire logic stall,
   // Select stream
   input wire logic sel_valid,
   output logic sel_ready
);
   // Ready moves just after an edge; random gaps mimic a slow interpolator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_ready <= 1'b0;
      end else begin
         sel_ready <= !stall && ($urandom % 3 != 0);
      end
   end
endmodule : mai_sink_model

// file: sim/motion_adaptive_interpolation_bench.sv
// Self-checking testbench for the motion-adaptive interpolation selector
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module motion_adaptive_interpolation_bench;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, override_sel_1, override_sel_2;
   logic pix_valid, pix_ready, sel_valid, sel_ready, stall;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, sel_frame, e;
   logic [23:0] cur_sample, adj_field_sample, next_frame_sample;
   int miscompares, checks_done, mode, aset, fcnt, s, c;
   int thr [3][3][2];
   int dl [8] = '{0, 1, 25, 26, 50, 51, 52, 255};
   logic [2:0] expq[$];

   mai_top mai_top_i (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .override_sel_1, .override_sel_2, .pix_valid, .pix_ready, .cur_sample,
      .adj_field_sample, .next_frame_sample, .sel_valid, .sel_ready, .sel_frame);
   mai_sink_model mai_sink_model_i (.clk, .rst_n, .stall, .sel_valid, .sel_ready);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic tmo();
      miscompares++;
      $display("Error at %0t: wait timed out", $time);
      end_sim();
   endtask : tmo

   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h00000, a};
      for (k = 0; k < 50; k++) begin @(posedge clk); if (hreadyout === 1'b1) break; end
      if (k == 50) tmo();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      for (k = 0; k < 50; k++) begin @(posedge clk); if (hreadyout === 1'b1) break; end
      if (k == 50) tmo();
      r = hrdata;
      `CHK(hresp, 1'b0)
   endtask : ahb

   task automatic wctl(input int m, input int t);
      ahb(1'b1, mai_pkg::ADDR_CTRL, {28'h0000000, 2'(t), 2'(m)}, rd);
      mode = (m == 3) ? 0 : m;
   endtask : wctl

   task automatic wthr(input int st, input int ch, input int tg, input logic [15:0] w);
      int f, r;
      wctl(mode, tg);
      ahb(1'b1, mai_pkg::ADDR_THR_BASE + 12'(st * 16 + ch * 4), {16'h0000, w}, rd);
      f = (w[7:0] > 100) ? 100 : w[7:0];
      r = (w[15:8] > 100) ? 100 : w[15:8];
      if (tg != 2) thr[st][ch][0] = f;
      if (tg == 0 || tg == 3) thr[st][ch][1] = f;
      if (tg == 2) thr[st][ch][1] = r;
   endtask : wthr

   task automatic chk_thr();
      for (int st = 0; st < 3; st++) begin
         for (int ch = 0; ch < 3; ch++) begin
            ahb(1'b0, mai_pkg::ADDR_THR_BASE + 12'(st * 16 + ch * 4), 32'h00000000, rd);
            `CHK(rd[15:0], {8'(thr[st][ch][1]), 8'(thr[st][ch][0])})
         end
      end
   endtask : chk_thr

   function automatic logic [2:0] exp_sel(input logic [23:0] cs, input logic [23:0] as, input logic [23:0] xs);
      logic [2:0] r;
      int m1, m2, t1, t2;
      for (int ch = 0; ch < 3; ch++) begin
         m1 = int'(cs[ch*8+:8]) - int'(as[ch*8+:8]);
         m2 = int'(cs[ch*8+:8]) - int'(xs[ch*8+:8]);
         if (m1 < 0) m1 = -m1;
         if (m2 < 0) m2 = -m2;
         t1 = thr[aset][ch][0];
         t2 = thr[aset][ch][1];
         r[ch] = (t1 >= 100 || m1 * 100 < t1 * 255) && (t2 >= 100 || m2 * 100 < t2 * 255);
      end
      if (mode == 1) r = 3'h0;
      if (mode == 2) r = 3'h7;
      return r;
   endfunction : exp_sel

   function automatic logic [7:0] mv(input logic [7:0] v, input int d);
      return (int'(v) + d <= 255) ? 8'(int'(v) + d) : 8'(int'(v) - d);
   endfunction : mv

   task automatic px(input int n);
      logic [23:0] cs, as, xs;
      int k;
      repeat (3) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         for (int ch = 0; ch < 3; ch++) begin
            cs[ch*8+:8] = 8'($urandom);
            as[ch*8+:8] = mv(cs[ch*8+:8], dl[$urandom % 8]);
            xs[ch*8+:8] = mv(cs[ch*8+:8], dl[$urandom % 8]);
         end
         pix_valid <= 1'b1;
         cur_sample <= cs;
         adj_field_sample <= as;
         next_frame_sample <= xs;
         for (k = 0; k < 300; k++) begin @(posedge clk); if (pix_ready === 1'b1) break; end
         if (k == 300) tmo();
         expq.push_back(exp_sel(cs, as, xs));
         if (exp_sel(cs, as, xs) != 3'h7) fcnt++;
      end
      pix_valid <= 1'b0;
   endtask : px

   task automatic drain();
      int k;
      for (k = 0; k < 500; k++) begin @(posedge clk); if (expq.size() == 0) break; end
      if (k == 500) tmo();
   endtask : drain

   always @(posedge clk) begin
      if (sel_valid === 1'b1 && sel_ready === 1'b1) begin
         if (expq.size() == 0) begin
            miscompares++;
            $display("Error at %0t: unexpected select", $time);
         end else begin
            e = expq.pop_front();
            `CHK(sel_frame, e)
         end
      end
   end

   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      override_sel_1 = 1'b0; override_sel_2 = 1'b0; pix_valid = 1'b0; stall = 1'b0;
      cur_sample = 24'h0; adj_field_sample = 24'h0; next_frame_sample = 24'h0;
      miscompares = 0; checks_done = 0; mode = 0; aset = 0; fcnt = 0;
      foreach (thr[i, j, k]) thr[i][j][k] = 10;
      void'($urandom(32'hF418E565));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      chk_thr();
      ahb(1'b0, mai_pkg::ADDR_CTRL, 32'h0, rd);
      `CHK(rd[3:0], 4'h0)
      $display("Test reset values done");
      wthr(0, 0, 1, 16'h0014);
      wthr(0, 1, 2, 16'h1E00);
      wthr(0, 2, 0, 16'h0096);
      wthr(0, 0, 2, 16'h3300);
      wthr(0, 2, 3, 16'h0032);
      ahb(1'b1, 12'h01C, 32'hFFFFFFFF, rd);
      ahb(1'b0, 12'h01C, 32'h0, rd);
      `CHK(rd, 32'h00000000)
      chk_thr();
      $display("Test threshold edits done");
      px(80);
      drain();
      $display("Test adaptive decisions done");
      for (int m = 0; m < 4; m++) begin
         wctl(m, 0);
         ahb(1'b0, mai_pkg::ADDR_CTRL, 32'h0, rd);
         `CHK(rd[1:0], 2'(mode))
         px(8);
         drain();
      end
      $display("Test forced modes done");
      for (c = 0; c < 3; c++) wthr(1, c, 0, 16'h0064);
      for (c = 0; c < 3; c++) wthr(2, c, 0, 16'h0000);
      for (s = 1; s < 5; s++) begin
         override_sel_1 <= s[0];
         override_sel_2 <= s[1];
         aset = (s == 2) ? 2 : (s == 4) ? 0 : 1;
         repeat (8) @(posedge clk);
         ahb(1'b0, mai_pkg::ADDR_STATUS, 32'h0, rd);
         `CHK(rd[1:0], 2'(aset))
         px(12);
         drain();
      end
      $display("Test alternate sets done");
      stall <= 1'b1;
      fork
         px(3);
      join_none
      repeat (15) @(posedge clk);
      `CHK(pix_ready, 1'b0)
      ahb(1'b0, mai_pkg::ADDR_STATUS, 32'h0, rd);
      `CHK(rd[3:2], 2'h2)
      stall <= 1'b0;
      wait fork;
      drain();
      ahb(1'b0, mai_pkg::ADDR_STATUS, 32'h0, rd);
      `CHK(rd[31:16], fcnt[15:0])
      $display("Test buffer stall done");
      end_sim();
   end
endmodule : motion_adaptive_interpolation_bench
